// file: logic/bic_boot_config.sv
// Boot interface configuration register with serial register access
// Function
// RL1 - Read 65h and write 71h register commands
// RL2 - Bit 7 boot address length, default 0
// RL3 - Length applies to configurable-address commands only
// RL4 - Programmed bit 7 boots four-byte mode
// RL5 - Bit 6 boot four-wire protocol, default 0
// RL6 - Programming bit 6 also programs quad default
// RL7 - Host enters four-wire via live bit
// RL8 - Host polls busy after boot programming
// RL9 - Live bit clears; boot bit never returns
// RL10 - Bit 5 enables line 3 reset input
// RL11 - Bit 4 reserved, reads zero
// RL12 - Bits 3:0 set dummy cycle count
// RL13 - Bit 3 defaults one, programmable once
// RL14 - Dummy count applies to variable-latency reads
// RL15 - Host clock limit for plain reads
// RL16 - Host clock limit for mode-cycle reads
// RL17 - Host avoids code 0 for DDR
// RL18 - Boot copy loads live copy on resets
// RL19 - Each boot bit is one-time programmable
// RL20 - Setting live four-wire bit sets live quad
// RL21 - Attempts to revert boot bits are ignored
`default_nettype none
module bic_boot_config #(
  parameter int PROG_CYCLES = bic_pkg::PROG_CYCLES // Busy time after boot programming
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Serial link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Line 3 reset pin, active low
  input wire logic line3_rst_n,
  // Software reset request, one-cycle pulse from local logic
  input wire logic sw_reset,
  // Configuration seen by the rest of the device
  output bic_pkg::bic_cfg_s live_cfg,
  output bic_pkg::bic_cfg_s boot_cfg,
  output logic live_quad_width,
  output logic boot_quad_width,
  output logic busy
);

  // ==========================================================
  // Declarations
  logic sck_s1, sck_s2, sck_s3; // sck synchroniser plus edge history
  logic cs_s1, cs_s2;           // cs_n synchroniser
  logic si_s1, si_s2;           // si synchroniser
  logic rst3_s1, rst3_s2;       // Line 3 reset synchroniser
  logic sck_rise, sck_fall;     // Link clock edges in the reference domain
  bic_pkg::bic_state_e state_q; // Frame state
  logic [5:0] cnt_q;            // Bit counter within a phase
  logic [7:0] cmd_q;            // Command shift register
  logic [31:0] addr_q;          // Address shift register
  logic is_write_q;             // Frame is a write-any
  logic [7:0] tx_q;             // Read data, rotated out
  logic [7:0] rx_next;          // Write data including the current bit
  logic [31:0] addr_next;       // Address including the current bit
  logic [5:0] addr_last;        // Index of final address bit
  logic [7:0] read_val;         // Register selected by the address
  logic wr_boot, wr_live;       // Commit strobes for the two copies
  logic [7:0] boot_merged;      // Boot value after one-time merge
  logic hw_reset;               // Line 3 reset is being asserted
  logic reload;                 // Load live copy from boot copy
  logic [$clog2(PROG_CYCLES+1)-1:0] busy_cnt_q; // Programming time left

  // ==========================================================
  // Functions
  // Address match; short addressing compares only the low three bytes
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] t,
                                    input logic four);
    addr_hit = four ? (a == t) : (a[23:0] == t[23:0]);
  endfunction

  // Bits may only leave their unprogrammed value, never return
  function automatic logic [7:0] otp_merge(input logic [7:0] old, input logic [7:0] req);
    logic [7:0] moved;
    moved = (old ^ bic_pkg::BOOT_RESET) | (req ^ bic_pkg::BOOT_RESET); // [RL19]
    otp_merge = (bic_pkg::BOOT_RESET ^ moved) & ~bic_pkg::RSVD_MASK; // [RL11]
  endfunction

  // ==========================================================
  // Pin synchronisers: two flops before any logic looks
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      si_s1 <= 1'b0;
      si_s2 <= 1'b0;
      rst3_s1 <= 1'b1;
      rst3_s2 <= 1'b1;
    end else begin
      sck_s1 <= sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      si_s1 <= si;
      si_s2 <= si_s1;
      rst3_s1 <= line3_rst_n;
      rst3_s2 <= rst3_s1;
    end
  end

  assign sck_rise = sck_s2 & ~sck_s3;
  assign sck_fall = ~sck_s2 & sck_s3;

  // ==========================================================
  // Combinational helpers
  assign rx_next = {tx_q[6:0], si_s2};
  assign addr_next = {addr_q[30:0], si_s2};
  // Address width follows the live length bit for these commands
  assign addr_last = live_cfg.addr_len ? 6'(bic_pkg::ADDR_BYTES_LONG * 8 - 1)
                                       : 6'(bic_pkg::ADDR_BYTES_SHORT * 8 - 1); // [RL3]

  // Readback picks whichever copy the address names; others read zero
  always_comb begin
    if (addr_hit(addr_next, bic_pkg::BOOT_REG_ADDR, live_cfg.addr_len)) begin
      read_val = boot_cfg;
    end else if (addr_hit(addr_next, bic_pkg::LIVE_REG_ADDR, live_cfg.addr_len)) begin
      read_val = live_cfg;
    end else begin
      read_val = 8'h00;
    end
  end

  // Writes commit on the eighth data bit while chip select is still low
  always_comb begin
    wr_boot = 1'b0;
    wr_live = 1'b0;
    if (state_q == bic_pkg::ST_DATA && is_write_q && sck_rise && cnt_q == 6'h07
        && !cs_s2) begin
      wr_boot = addr_hit(addr_q, bic_pkg::BOOT_REG_ADDR, live_cfg.addr_len) && !busy; // [RL1]
      wr_live = addr_hit(addr_q, bic_pkg::LIVE_REG_ADDR, live_cfg.addr_len); // [RL1]
    end
  end

  assign boot_merged = otp_merge(boot_cfg, rx_next);
  // Line 3 only acts as reset while it carries no data
  assign hw_reset = live_cfg.line3_reset_en && !rst3_s2
                    && (cs_s2 || !live_quad_width); // [RL10]
  assign reload = sw_reset || hw_reset;

  // ==========================================================
  // Frame state machine and shift registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= bic_pkg::ST_IDLE;
      cnt_q <= 6'h00;
      cmd_q <= 8'h00;
      addr_q <= 32'h00000000;
      is_write_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (cs_s2) begin
      // Deselect ends any frame
      state_q <= bic_pkg::ST_IDLE;
      cnt_q <= 6'h00;
    end else begin
      case (state_q)
        bic_pkg::ST_IDLE: begin
          state_q <= bic_pkg::ST_CMD;
          cnt_q <= 6'h00;
        end
        bic_pkg::ST_CMD: if (sck_rise) begin
          cmd_q <= {cmd_q[6:0], si_s2};
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'h07) begin
            cnt_q <= 6'h00;
            // Only serial instructions are decoded here; wide decode lives upstream
            if ({cmd_q[6:0], si_s2} == bic_pkg::CMD_READ_ANY) begin // [RL1]
              state_q <= bic_pkg::ST_ADDR;
              is_write_q <= 1'b0;
            end else if ({cmd_q[6:0], si_s2} == bic_pkg::CMD_WRITE_ANY) begin // [RL1]
              state_q <= bic_pkg::ST_ADDR;
              is_write_q <= 1'b1;
            end else begin
              state_q <= bic_pkg::ST_IGNORE;
            end
          end
        end
        bic_pkg::ST_ADDR: if (sck_rise) begin
          addr_q <= addr_next;
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == addr_last) begin
            cnt_q <= 6'h00;
            tx_q <= read_val;
            if (is_write_q || live_cfg.dummy_count == 4'h0) begin
              state_q <= bic_pkg::ST_DATA;
            end else begin
              state_q <= bic_pkg::ST_DUMMY; // [RL14]
            end
          end
        end
        bic_pkg::ST_DUMMY: if (sck_rise) begin
          cnt_q <= cnt_q + 6'h01;
          // Live dummy count sets the read-any latency
          if (cnt_q == {2'b00, live_cfg.dummy_count} - 6'h01) begin // [RL12] [RL14]
            cnt_q <= 6'h00;
            state_q <= bic_pkg::ST_DATA;
          end
        end
        bic_pkg::ST_DATA: begin
          if (is_write_q && sck_rise) begin
            tx_q <= rx_next;
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'h07) begin
              state_q <= bic_pkg::ST_IGNORE;
            end
          end else if (!is_write_q && sck_fall) begin
            // Reads rotate so the same byte repeats while clocked
            tx_q <= {tx_q[6:0], tx_q[7]};
          end
        end
        bic_pkg::ST_IGNORE: begin
          cnt_q <= 6'h00;
        end
        default: begin
          state_q <= bic_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Serial output: driven on falling edges during read data
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (cs_s2 || state_q != bic_pkg::ST_DATA || is_write_q) begin
      so_oe <= 1'b0;
    end else if (sck_fall) begin
      so <= tx_q[7];
      so_oe <= 1'b1;
    end
  end

  // ==========================================================
  // Boot (one-time) copy; never touched by hardware or software reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      boot_cfg <= bic_pkg::BOOT_RESET; // [RL2] [RL5] [RL13]
      boot_quad_width <= bic_pkg::BOOT_QUAD_RESET;
    end else if (wr_boot) begin
      // Reverting bits are dropped, others take the written value
      boot_cfg <= boot_merged; // [RL9] [RL13] [RL21]
      if (boot_merged[bic_pkg::WIDE_INSTR_BIT]) begin
        boot_quad_width <= 1'b1; // [RL6]
      end
    end
  end

  // ==========================================================
  // Busy timer after a boot write; host polls this
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt_q <= '0;
      busy <= 1'b0;
    end else if (wr_boot) begin
      busy_cnt_q <= ($clog2(PROG_CYCLES+1))'(PROG_CYCLES); // [RL8]
      busy <= 1'b1;
    end else if (busy_cnt_q != '0) begin
      busy_cnt_q <= busy_cnt_q - ($clog2(PROG_CYCLES+1))'(1);
      busy <= (busy_cnt_q != ($clog2(PROG_CYCLES+1))'(1));
    end else begin
      busy <= 1'b0;
    end
  end

  // ==========================================================
  // Live copy: loaded from boot on any reset, else written directly
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      live_cfg <= bic_pkg::BOOT_RESET; // [RL18]
      live_quad_width <= bic_pkg::BOOT_QUAD_RESET;
    end else if (reload) begin
      // Boot copy decides address length, protocol and latency
      live_cfg <= boot_cfg; // [RL4] [RL18]
      live_quad_width <= boot_quad_width; // [RL18]
    end else if (wr_live) begin
      live_cfg <= rx_next & ~bic_pkg::RSVD_MASK; // [RL7] [RL9] [RL11]
      if (rx_next[bic_pkg::WIDE_INSTR_BIT]) begin
        live_quad_width <= 1'b1; // [RL20]
      end
    end
  end

endmodule : bic_boot_config
`default_nettype wire

// file: shared/bic_pkg.sv
// Package: constants, field layout and types for the boot interface config block
`default_nettype none
package bic_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_READ_ANY = 8'h65;  // Read-any-register
  localparam logic [7:0] CMD_WRITE_ANY = 8'h71; // Write-any-register

  // ==========================================================
  // Field positions inside the config byte
  localparam int ADDR_LEN_BIT = 7;   // 1 = four address bytes
  localparam int WIDE_INSTR_BIT = 6; // 1 = four-wire protocol
  localparam int LINE3_RST_BIT = 5;  // 1 = line 3 is a reset input
  localparam int RSVD_BIT = 4;       // Reserved, reads zero
  localparam int DUMMY_MSB = 3;      // Dummy count field top bit
  localparam int DUMMY_LSB = 0;      // Dummy count field low bit

  // ==========================================================
  // Reset values and masks
  localparam logic [7:0] BOOT_RESET = 8'h08;  // Unprogrammed state, dummy code 8
  localparam logic [7:0] RSVD_MASK = 8'h10;   // Reserved bit mask
  localparam logic BOOT_QUAD_RESET = 1'b0;    // Unprogrammed quad-width default
  localparam int ADDR_BYTES_SHORT = 3;        // Address bytes when addr_len = 0
  localparam int ADDR_BYTES_LONG = 4;         // Address bytes when addr_len = 1

  // ==========================================================
  // Register addresses seen by the two commands
  localparam logic [31:0] BOOT_REG_ADDR = 32'h00000003; // Non-volatile copy
  localparam logic [31:0] LIVE_REG_ADDR = 32'h00800003; // Volatile copy

  // ==========================================================
  // Timing: one-time programming busy time
  localparam int PROG_TIME_NS = 1000;                 // Programming time
  localparam int CLK_PERIOD_NS = 5;                   // 200 MHz reference clock
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Types
  typedef struct packed {
    logic addr_len;        // Configurable-address commands use 4 bytes
    logic wide_instr;      // Four-wire protocol for every transfer
    logic line3_reset_en;  // Line 3 doubles as hardware reset
    logic rsvd;            // Reserved
    logic [3:0] dummy_count; // Dummy cycles in variable-latency reads
  } bic_cfg_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,   // Chip select high
    ST_CMD = 6'h02,    // Shifting in command byte
    ST_ADDR = 6'h04,   // Shifting in address
    ST_DUMMY = 6'h08,  // Dummy cycles before read data
    ST_DATA = 6'h10,   // Register data in or out
    ST_IGNORE = 6'h20  // Rest of frame ignored
  } bic_state_e;
endpackage : bic_pkg
`default_nettype wire

// file: sim/bic_boot_config_monitor.sv
// Port-level checker for the boot interface config block
`default_nettype none
module bic_boot_config_monitor #(
  parameter int PROG_CYCLES = 8 // Busy time expected after boot programming
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Pins and requests
  input wire logic cs_n,
  input wire logic line3_rst_n,
  input wire logic sw_reset,
  // Watched outputs
  input wire logic so_oe,
  input wire bic_pkg::bic_cfg_s live_cfg,
  input wire bic_pkg::bic_cfg_s boot_cfg,
  input wire logic live_quad_width,
  input wire logic boot_quad_width,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] busy_len_q; // Cycles that busy has stood so far
  // ==========================================================
  // Busy length counter; keeps the long count out of a repetition
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) busy_len_q <= 16'h0000;
    else if (busy) busy_len_q <= busy_len_q + 16'h0001;
    else busy_len_q <= 16'h0000;
  end
  // ==========================================================
  // Properties
  property p_rsvd_zero; !live_cfg.rsvd && !boot_cfg.rsvd; endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit seen set");
  // Boot bits other than bits 4 and 3 may only go from 0 to 1
  property p_boot_sticky; ($past(boot_cfg) & ~boot_cfg & 8'he7) == 8'h00; endproperty
  a_boot_sticky: assert property (p_boot_sticky) else $error("boot bit reverted");
  property p_msb_once; !$past(boot_cfg.dummy_count[3]) |-> !boot_cfg.dummy_count[3]; endproperty
  a_msb_once: assert property (p_msb_once) else $error("boot dummy msb reset");
  property p_boot_quad; $rose(boot_cfg.wide_instr) |-> ##[0:1] boot_quad_width; endproperty
  a_boot_quad: assert property (p_boot_quad) else $error("boot quad not set");
  property p_live_quad; $rose(live_cfg.wide_instr) |-> ##[0:1] live_quad_width; endproperty
  a_live_quad: assert property (p_live_quad) else $error("live quad not set");
  property p_sw_reload;
    sw_reset |=> live_cfg == $past(boot_cfg) && live_quad_width == $past(boot_quad_width);
  endproperty
  a_sw_reload: assert property (p_sw_reload) else $error("soft reset did not reload");
  // Pin reset goes through a synchroniser, so allow a few cycles
  property p_pin_reload;
    (!line3_rst_n && live_cfg.line3_reset_en && cs_n) [*4] |-> ##[0:4] live_cfg == boot_cfg;
  endproperty
  a_pin_reload: assert property (p_pin_reload) else $error("pin reset did not reload");
  property p_busy_len; $fell(busy) |-> busy_len_q == PROG_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_cap; busy_len_q <= PROG_CYCLES; endproperty
  a_busy_cap: assert property (p_busy_cap) else $error("busy stands too long");
  property p_oe_idle; cs_n [*6] |-> !so_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
  c_prog: cover property ($rose(busy));
  c_sw: cover property (sw_reset ##1 live_cfg.addr_len);
  c_read: cover property ($rose(so_oe));
endmodule // bic_boot_config_monitor
bind bic_boot_config bic_boot_config_monitor #(.PROG_CYCLES(PROG_CYCLES))
  i_bic_boot_config_monitor (.ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n),
  .line3_rst_n(line3_rst_n), .sw_reset(sw_reset), .so_oe(so_oe), .live_cfg(live_cfg),
  .boot_cfg(boot_cfg), .live_quad_width(live_quad_width),
  .boot_quad_width(boot_quad_width), .busy(busy));
`default_nettype wire

// file: sim/bic_host_model.sv
// Host serial controller model driving the link pins in mode 0
`default_nettype none
module bic_host_model #(
  parameter int HALF_NS = 24 // Half of a 48 ns link period, well under every limit
) (
  // Reference clock, only used to place frame starts
  input wire logic ref_clk,
  // Link pins
  output var logic sck,
  output var logic cs_n,
  output var logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Idle link: clock parked low, select high
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // ==========================================================
  // One frame: command, address, then write byte or dummy plus read byte
  task automatic frame(input logic [7:0] cmd, input logic [31:0] adr, input int ab,
                       input int dm, input logic [7:0] wd, output logic [7:0] rd);
    logic [71:0] sh; // Bits still to send, MSB first
    int n; // Link cycles in this frame
    sh = (ab == 4) ? {cmd, adr, wd, 24'h0} : {cmd, adr[23:0], wd, 32'h0};
    n = 16 + 8 * ab + dm;
    rd = 8'h00;
    @(posedge ref_clk);
    // Offset keeps link edges off every reference clock edge
    #1.2 cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      si <= sh[71];
      sh = sh << 1;
      // Sample just before the rising edge; only the last 8 matter
      #(HALF_NS) rd = {rd[6:0], so};
      sck <= 1'b1;
      #(HALF_NS) sck <= 1'b0;
    end
    #(HALF_NS) cs_n <= 1'b1;
    // Released line shows the inverse, not a stale value
    si <= ~si;
    #40; // Deselect gap before the next frame
  endtask
endmodule // bic_host_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the boot interface config register
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Pins and bench state
  logic ref_clk, rstn, sck, cs_n, si, so, so_oe, line3_rst_n, sw_reset;
  logic live_quad_width, boot_quad_width, busy;
  bic_pkg::bic_cfg_s live_cfg, boot_cfg;
  logic [7:0] rd; // Byte returned by the last frame
  logic oe_seen = 1'b0; // Output enable was raised by a read at least once
  int n_errors, num_checks, cyc;
  localparam logic [7:0] rc = bic_pkg::CMD_READ_ANY; // Read command
  localparam logic [7:0] wc = bic_pkg::CMD_WRITE_ANY; // Write command
  localparam logic [31:0] la = bic_pkg::LIVE_REG_ADDR; // Live copy
  localparam logic [31:0] ba = bic_pkg::BOOT_REG_ADDR; // Boot copy
  localparam logic [31:0] ua = 32'h00001234; // Unmapped place
  // Row: command, address, write byte, expected read, address bytes, dummy count
  typedef struct packed {
    logic [7:0] cmd; logic [31:0] adr; logic [7:0] wd;
    logic [7:0] ex; logic [3:0] ab; logic [3:0] dm;
  } bic_row_s;
  bic_row_s rows [14] = '{
    '{rc, la, 8'h00, 8'h08, 4'h3, 4'h8}, // Reset dummy code 8
    '{wc, la, 8'h5a, 8'h00, 4'h3, 4'h0}, // Live four-wire on, reserved written 1
    '{rc, la, 8'h00, 8'h4a, 4'h3, 4'ha},
    '{wc, la, 8'h0f, 8'h00, 4'h3, 4'h0}, // Four-wire off, quad must stay
    '{8'h3c, la, 8'hf0, 8'h00, 4'h3, 4'h0}, // Unknown command, whole frame ignored
    '{rc, la, 8'h00, 8'h0f, 4'h3, 4'hf}, // Largest dummy count
    '{rc, ba, 8'h00, 8'h08, 4'h3, 4'hf},
    '{wc, ua, 8'hff, 8'h00, 4'h3, 4'h0}, // Dropped
    '{rc, ua, 8'h00, 8'h00, 4'h3, 4'hf},
    '{wc, la, 8'h80, 8'h00, 4'h3, 4'h0}, // Four address bytes, no dummy
    '{rc, la, 8'h00, 8'h80, 4'h4, 4'h0},
    '{wc, ba, 8'he5, 8'h00, 4'h4, 4'h0}, // Program boot copy
    '{wc, ba, 8'h08, 8'h00, 4'h4, 4'h0}, // Try to revert every bit
    '{rc, ba, 8'h00, 8'he5, 4'h4, 4'h0}};
  // ==========================================================
  // Design, host and clock
  bic_boot_config #(.PROG_CYCLES(8)) i_bic_boot_config (.ref_clk(ref_clk), .rstn(rstn),
    .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .line3_rst_n(line3_rst_n),
    .sw_reset(sw_reset), .live_cfg(live_cfg), .boot_cfg(boot_cfg),
    .live_quad_width(live_quad_width), .boot_quad_width(boot_quad_width), .busy(busy));
  bic_host_model i_bic_host_model (.ref_clk(ref_clk), .sck(sck), .cs_n(cs_n), .si(si),
    .so(so));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Hang guard: the whole run needs roughly 8000 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    // Remember that the data pin was driven at least once
    if (so_oe === 1'b1) begin
      oe_seen <= 1'b1;
    end
    if (cyc == 30000) begin
      n_errors++;
      finish_test;
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait for programming to finish, ends on a clock edge
  task automatic wait_idle;
    repeat (2) @(posedge ref_clk);
    for (int k = 0; k < 100 && busy !== 1'b0; k++) @(posedge ref_clk);
    check("busy", 8'h00, {7'h00, busy});
  endtask
  // Hold the line 3 pin low with the link deselected
  task automatic pin_pulse;
    line3_rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    line3_rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    line3_rst_n = 1'b1;
    sw_reset = 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check("live_cfg", bic_pkg::BOOT_RESET, live_cfg);
    check("boot_cfg", bic_pkg::BOOT_RESET, boot_cfg);
    check("flags", 8'h00, {4'h0, live_quad_width, boot_quad_width, busy, so_oe});
    $display("test reset done");
    for (int i = 0; i < 14; i++) begin
      i_bic_host_model.frame(rows[i].cmd, rows[i].adr, int'(rows[i].ab), int'(rows[i].dm),
                             rows[i].wd, rd);
      if (rows[i].cmd == rc) check("read_data", rows[i].ex, rd);
      wait_idle;
      $display("test row %0d done", i);
    end
    check("quads", 8'h03, {6'h00, live_quad_width, boot_quad_width});
    check("so_oe_seen", 8'h01, {7'h00, oe_seen});
    check("live_cfg", 8'h80, live_cfg);
    check("boot_cfg", 8'he5, boot_cfg);
    sw_reset <= 1'b1;
    @(posedge ref_clk);
    sw_reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("live_cfg", 8'he5, live_cfg);
    i_bic_host_model.frame(rc, la, 4, 5, 8'h00, rd);
    check("read_data", 8'he5, rd);
    $display("test soft reset done");
    i_bic_host_model.frame(wc, la, 4, 0, 8'hb1, rd);
    wait_idle;
    check("live_cfg", 8'ha1, live_cfg);
    pin_pulse;
    check("live_cfg", 8'he5, live_cfg);
    i_bic_host_model.frame(wc, la, 4, 0, 8'h81, rd);
    wait_idle;
    pin_pulse;
    check("live_cfg", 8'h81, live_cfg);
    $display("test pin reset done");
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
